// ===== utp_pkg.sv
// constants and types shared by the user test pattern register bank
package utp_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [1:0] ADDR_CTRL   = 2'h0;
   localparam logic [1:0] ADDR_UPPER  = 2'h1;
   localparam logic [1:0] ADDR_LOWER  = 2'h2;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam logic [7:0] READ_NONE   = 8'h00;

   // ************************************************************
   // field layout
   // ************************************************************
   localparam int UPPER_FIELD_HI = 5;
   localparam int UPPER_FIELD_LO = 0;
   localparam int LOWER_FIELD_HI = 7;
   localparam int LOWER_FIELD_LO = 2;
   localparam int WORD_BITS      = 12;

   // ************************************************************
   // serial frame
   // ************************************************************
   localparam logic [4:0] CMD_BITS   = 5'h08;
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam int         RW_POS     = 7;
   localparam int         ADDR_HI    = 1;
   localparam int         ADDR_LO    = 0;

   // ************************************************************
   // operating mode
   // ************************************************************
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_USER   = 2'h2;

   typedef enum logic [1:0] {
      UTP_IDLE,
      UTP_CMD,
      UTP_DATA,
      UTP_DONE
   } utp_state_t;

endpackage

// ===== utp_out_if.sv
// carrier between register bank and output word selector
interface utp_out_if;
   logic [11:0] userWord;
   logic [1:0]  opMode;
   logic [11:0] convWord;
   logic [11:0] outWord;
   logic        testActive;

   modport bank (
      output userWord,
      output opMode,
      output convWord,
      input  outWord,
      input  testActive
   );

   modport sel (
      input  userWord,
      input  opMode,
      input  convWord,
      output outWord,
      output testActive
   );
endinterface

// ===== utp_out_sel.sv
// selects user test word or conversion result for the serializer
module utp_out_sel (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic clkEn,
   utp_out_if.sel    port
);

   logic [11:0] next_outWord;
   logic        next_testActive;

   always_comb begin
      next_testActive = (port.opMode == utp_pkg::MODE_USER);
      next_outWord    = next_testActive ? port.userWord : port.convWord;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         port.outWord    <= 12'h000;
         port.testActive <= 1'b0;
      end else if (clkEn) begin
         port.outWord    <= next_outWord;
         port.testActive <= next_testActive;
      end
   end

endmodule

// ===== utp_regs.sv
// user test pattern registers behind the serial control port
//
// Contract
// - word bits 11:6 from upper reg 5:0
// - word bits 5:0 from lower reg 7:2
// - upper at 1, lower at 2, reset zero
// - user word drives outputs only in test
// - mode field binary 10 selects user word
// - write commits when select deasserts
module utp_regs (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        clkEn,
   input  wire logic        serialClk,
   input  wire logic        serial_select_low,
   input  wire logic        serialDataIn,
   input  wire logic [1:0]  opMode,
   input  wire logic [11:0] convWord,
   output logic             serialDataOut,
   output logic             serialDataOutEn,
   output logic [11:0]      outWord,
   output logic             testActive
);

   // ************************************************************
   // state
   // ************************************************************
   utp_pkg::utp_state_t state;
   utp_pkg::utp_state_t next_state;
   logic [7:0]  userPatternUpper;
   logic [7:0]  userPatternLower;
   logic [7:0]  next_userPatternUpper;
   logic [7:0]  next_userPatternLower;
   logic        clkPrev;
   logic        selPrev;
   logic        next_clkPrev;
   logic        next_selPrev;
   logic [4:0]  bitCount;
   logic [4:0]  next_bitCount;
   logic [15:0] shiftIn;
   logic [15:0] next_shiftIn;
   logic        isRead;
   logic        next_isRead;
   logic [7:0]  readShift;
   logic [7:0]  next_readShift;
   logic        next_serialDataOut;
   logic        next_serialDataOutEn;
   logic        clkRise;
   logic        clkFall;
   logic        selRelease;
   logic        selected;

   utp_out_if outBus ();

   // ************************************************************
   // helper functions
   // ************************************************************
   function automatic logic [15:0] shiftBit(input logic [15:0] frame,
                                            input logic        newBit);
      shiftBit = {frame[14:0], newBit};
   endfunction

   // five bits hold sixteen rises without wrapping
   function automatic logic [4:0] countUp(input logic [4:0] count);
      countUp = count + 5'h01;
   endfunction

   function automatic logic [1:0] cmdAddr(input logic [7:0] cmd);
      cmdAddr = cmd[utp_pkg::ADDR_HI:utp_pkg::ADDR_LO];
   endfunction

   function automatic logic [7:0] readReg(input logic [1:0] addr,
                                          input logic [7:0] upper,
                                          input logic [7:0] lower);
      case (addr)
         utp_pkg::ADDR_UPPER: readReg = upper;
         utp_pkg::ADDR_LOWER: readReg = lower;
         default:             readReg = utp_pkg::READ_NONE;
      endcase
   endfunction

   // ************************************************************
   // pin edge detection
   // ************************************************************
   // pins are synchronous to core_clk, so one history flop suffices
   // selPrev resets high so leaving reset is never a release
   assign selected   = !serial_select_low;
   assign clkRise    = selected && serialClk && !clkPrev;
   assign clkFall    = selected && !serialClk && clkPrev;
   assign selRelease = serial_select_low && !selPrev;

   // ************************************************************
   // serial frame
   // ************************************************************
   always_comb begin
      next_state           = state;
      next_bitCount        = bitCount;
      next_shiftIn         = shiftIn;
      next_isRead          = isRead;
      next_readShift       = readShift;
      next_serialDataOut   = serialDataOut;
      next_serialDataOutEn = selected;
      next_clkPrev         = serialClk;
      next_selPrev         = serial_select_low;
      if (!selected) begin
         next_state    = utp_pkg::UTP_IDLE;
         next_bitCount = 5'h00;
         next_isRead   = 1'b0;
      end else begin
         case (state)
            utp_pkg::UTP_IDLE: begin
               next_state = utp_pkg::UTP_CMD;
            end
            utp_pkg::UTP_CMD: begin
               if (clkRise) begin
                  next_shiftIn  = shiftBit(shiftIn, serialDataIn);
                  next_bitCount = countUp(bitCount);
                  if (next_bitCount == utp_pkg::CMD_BITS) begin
                     next_state     = utp_pkg::UTP_DATA;
                     next_isRead    = next_shiftIn[utp_pkg::RW_POS];
                     next_readShift = readReg(cmdAddr(next_shiftIn[7:0]),
                                              userPatternUpper, userPatternLower);
                  end
               end
            end
            utp_pkg::UTP_DATA: begin
               // data leaves on falling edges so the host samples it on rising ones
               if (clkFall) begin
                  next_serialDataOut = readShift[7];
                  next_readShift     = {readShift[6:0], 1'b0};
               end
               if (clkRise) begin
                  next_shiftIn  = shiftBit(shiftIn, serialDataIn);
                  next_bitCount = countUp(bitCount);
                  if (next_bitCount == utp_pkg::FRAME_BITS) begin
                     next_state = utp_pkg::UTP_DONE;
                  end
               end
            end
            utp_pkg::UTP_DONE: begin
               // extra clocks after a full frame are ignored
               next_state = utp_pkg::UTP_DONE;
            end
            default: begin
               next_state = utp_pkg::UTP_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state           <= utp_pkg::UTP_IDLE;
         bitCount        <= 5'h00;
         shiftIn         <= 16'h0000;
         isRead          <= 1'b0;
         readShift       <= 8'h00;
         serialDataOut   <= 1'b0;
         serialDataOutEn <= 1'b0;
         clkPrev         <= 1'b0;
         selPrev         <= 1'b1;
      end else if (clkEn) begin
         state           <= next_state;
         bitCount        <= next_bitCount;
         shiftIn         <= next_shiftIn;
         isRead          <= next_isRead;
         readShift       <= next_readShift;
         serialDataOut   <= next_serialDataOut;
         serialDataOutEn <= next_serialDataOutEn;
         clkPrev         <= next_clkPrev;
         selPrev         <= next_selPrev;
      end
   end

   // ************************************************************
   // pattern registers
   // ************************************************************
   // reserved bits are stored as written; the host keeps them zero
   always_comb begin
      next_userPatternUpper = userPatternUpper;
      next_userPatternLower = userPatternLower;
      // a short or aborted frame commits nothing
      if (selRelease && state == utp_pkg::UTP_DONE && !isRead) begin
         case (cmdAddr(shiftIn[15:8]))
            utp_pkg::ADDR_UPPER: next_userPatternUpper = shiftIn[7:0];
            utp_pkg::ADDR_LOWER: next_userPatternLower = shiftIn[7:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         userPatternUpper <= utp_pkg::RESET_VALUE;
         userPatternLower <= utp_pkg::RESET_VALUE;
      end else if (clkEn) begin
         userPatternUpper <= next_userPatternUpper;
         userPatternLower <= next_userPatternLower;
      end
   end

   // ************************************************************
   // output word
   // ************************************************************
   // reserved bits never reach the serializer
   assign outBus.userWord = {userPatternUpper[utp_pkg::UPPER_FIELD_HI:utp_pkg::UPPER_FIELD_LO],
                             userPatternLower[utp_pkg::LOWER_FIELD_HI:utp_pkg::LOWER_FIELD_LO]};
   assign outBus.opMode   = opMode;
   assign outBus.convWord = convWord;
   assign outWord         = outBus.outWord;
   assign testActive      = outBus.testActive;

   utp_out_sel outSel (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .clkEn    (clkEn),
      .port     (outBus.sel)
   );

endmodule

// ===== utp_host.sv
// host model driving the serial control port
module utp_host (
   input  wire logic core_clk,
   input  wire logic serialDataOut,
   output logic      serialClk,
   output logic      serial_select_low,
   output logic      serialDataIn
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      serialClk = 1'b0;
      serial_select_low = 1'b1;
      serialDataIn = 1'b0;
   end
   // three core cycles per serial clock level, above the two-cycle minimum
   task automatic xfer(input logic [15:0] f, input int n, output logic [7:0] rd);
      rd = 8'h00;
      serial_select_low = 1'b0;
      repeat (3) @(negedge core_clk);
      for (int i = 0; i < n; i++) begin
         serialDataIn = f[15 - i];
         repeat (3) @(negedge core_clk);
         if (i > 7) rd = {rd[6:0], serialDataOut};
         serialClk = 1'b1;
         repeat (3) @(negedge core_clk);
         serialClk = 1'b0;
      end
      repeat (3) @(negedge core_clk);
      serial_select_low = 1'b1;
      // released line must not keep the last bit
      serialDataIn = ~serialDataIn;
      repeat (4) @(negedge core_clk);
   endtask
endmodule

// ===== utp_regs_checker.sv
// port assertions for the pattern register bank
module utp_regs_checker (
   input wire logic        core_clk,
   input wire logic        rst_b,
   input wire logic        clkEn,
   input wire logic        serialClk,
   input wire logic        serial_select_low,
   input wire logic        serialDataIn,
   input wire logic [1:0]  opMode,
   input wire logic [11:0] convWord,
   input wire logic        serialDataOut,
   input wire logic        serialDataOutEn,
   input wire logic [11:0] outWord,
   input wire logic        testActive
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] USR = utp_pkg::MODE_USER;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   chk_reset_quiet: assert property (disable iff (1'b0)
      !rst_b |-> outWord == 12'h000 && !testActive && !serialDataOutEn) else $error("outputs not cleared");
   chk_pass_conv: assert property (clkEn && opMode != USR |=> outWord == $past(convWord))
      else $error("conversion word not passed");
   chk_mode_flag: assert property (clkEn |=> testActive == ($past(opMode) == USR))
      else $error("test flag wrong");
   chk_idle_hold: assert property ((clkEn && opMode == USR && serial_select_low) [*4] |=> $stable(outWord))
      else $error("user word moved while idle");
   chk_frame_hold: assert property ((clkEn && opMode == USR && !serial_select_low) [*3] |=> $stable(outWord))
      else $error("user word moved inside frame");
   chk_commit_time: assert property (clkEn && testActive && $past(testActive) && $changed(outWord)
      |-> $past(serial_select_low, 2) && !$past(serial_select_low, 3)) else $error("commit at wrong time");
   chk_oe_follow: assert property ($past(clkEn) |-> serialDataOutEn == !$past(serial_select_low))
      else $error("output enable wrong");
   chk_exit_user: assert property (clkEn && $past(opMode) == USR && opMode == utp_pkg::MODE_NORMAL
      |=> !testActive && outWord == $past(convWord)) else $error("user word kept after mode exit");
   cover property (testActive && !serial_select_low);
   cover property ($rose(serial_select_low) && testActive);
   cover property (serialDataOutEn && serialDataOut);
endmodule

bind utp_regs utp_regs_checker chk (.core_clk, .rst_b, .clkEn, .serialClk, .serial_select_low, .serialDataIn,
   .opMode, .convWord, .serialDataOut, .serialDataOutEn, .outWord, .testActive);

// ===== utp_regs_tb.sv
// self-checking bench for the user test pattern register bank
module utp_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, rst_b, clkEn, serialClk, serial_select_low, serialDataIn;
   logic        serialDataOut, serialDataOutEn, testActive;
   logic [1:0]  opMode;
   logic [11:0] convWord, outWord;
   logic [7:0]  rd, up, lo;
   logic [11:0] held;
   logic [31:0] lfsr = 32'h8722;
   int          error_cnt = 0;
   int          checked = 0;
   int          cyc = 0;
   utp_regs dut (.core_clk, .rst_b, .clkEn, .serialClk, .serial_select_low, .serialDataIn, .opMode, .convWord,
      .serialDataOut, .serialDataOutEn, .outWord, .testActive);
   utp_host host (.core_clk, .serialDataOut, .serialClk, .serial_select_low, .serialDataIn);
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [11:0] exp_word(input logic [1:0] m, input logic [7:0] u, input logic [7:0] l,
      input logic [11:0] c);
      return (m == utp_pkg::MODE_USER) ? {u[5:0], l[7:2]} : c;
   endfunction
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("mismatches %0d comparisons %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      host.xfer({1'b0, 5'h00, a, d}, 16, rd);
   endtask
   task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
      host.xfer({1'b1, 5'h00, a, 8'h00}, 16, rd);
      check({4'h0, rd}, {4'h0, e});
   endtask
   // whole run needs about 5000 cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test();
      end
   end
   initial begin
      rst_b = 1'b0;
      clkEn = 1'b1;
      opMode = utp_pkg::MODE_NORMAL;
      convWord = 12'h000;
      repeat (16) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (2) @(negedge core_clk);
      for (int a = 0; a < 4; a++) rd_chk(a[1:0], 8'h00);
      for (int k = 0; k < 8; k++) begin
         lfsr = next_rand(lfsr);
         convWord = lfsr[27:16];
         opMode = k[1:0];
         up = (k == 2) ? 8'h3F : {2'h0, lfsr[13:8]};
         lo = (k == 2) ? 8'hFC : {lfsr[7:2], 2'h0};
         wr(utp_pkg::ADDR_UPPER, up);
         wr(utp_pkg::ADDR_LOWER, lo);
         wr(2'h3, ~up);
         check(outWord, exp_word(opMode, up, lo, convWord));
         check({11'h000, testActive}, {11'h000, opMode == utp_pkg::MODE_USER});
         rd_chk(utp_pkg::ADDR_UPPER, up);
         rd_chk(utp_pkg::ADDR_LOWER, lo);
      end
      // frame cut one clock short must leave the register alone
      opMode = utp_pkg::MODE_USER;
      host.xfer({1'b0, 5'h00, utp_pkg::ADDR_UPPER, 8'h15}, 15, rd);
      rd_chk(utp_pkg::ADDR_UPPER, up);
      check(outWord, exp_word(opMode, up, lo, convWord));
      rst_b = 1'b0;
      repeat (3) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (2) @(negedge core_clk);
      check(outWord, 12'h000);
      rd_chk(utp_pkg::ADDR_LOWER, 8'h00);
      opMode = utp_pkg::MODE_NORMAL;
      convWord = lfsr[11:0];
      repeat (2) @(negedge core_clk);
      check(outWord, convWord);
      // low clock enable must freeze the output word
      held = convWord;
      clkEn = 1'b0;
      convWord = ~held;
      repeat (3) @(negedge core_clk);
      check(outWord, held);
      clkEn = 1'b1;
      repeat (2) @(negedge core_clk);
      check(outWord, ~held);
      check({11'h000, serialDataOutEn}, 12'h000);
      finish_test();
   end
endmodule
